//--- clock_synth_pkg.sv
// Register map, field layout and reset values of the synthesizer configuration bank
`default_nettype none
package clock_synth_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_INPUTS = 4;
	localparam int NUM_DIVIDERS = 5;
	localparam int NUM_REGS = 19;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [DATA_W-1:0] data_t;

	// Register offsets
	localparam addr_t RAMP_CONTROL_ADDR = 16'h05a6;
	localparam addr_t REF_PIN_CONFIG_ADDR = 16'h090e;
	localparam addr_t CONTROL_IO_LEVEL_ADDR = 16'h0943;
	localparam addr_t INPUT_BUFFER_CONTROL_ADDR = 16'h0949;
	localparam addr_t INPUT_TO_DETECTOR_ENABLE_ADDR = 16'h094a;
	localparam addr_t INPUT_HYSTERESIS_LOW_ADDR = 16'h094e;
	localparam addr_t INPUT_HYSTERESIS_HIGH_ADDR = 16'h094f;
	localparam addr_t FEEDBACK_DIVIDER_MODE_ADDR = 16'h095e;
	localparam addr_t DIVIDER_HALF_STEP_ADDR = 16'h0a02;
	localparam addr_t DIVIDER_ROUTE_ENABLE_ADDR = 16'h0a03;
	localparam addr_t DIVIDER_INTEGER_SELECT_ADDR = 16'h0a04;
	localparam addr_t DIVIDER_POWER_ADDR = 16'h0a05;
	localparam addr_t DIVIDER0_HIGH_RATE_ADDR = 16'h0a14;
	localparam addr_t DIVIDER1_HIGH_RATE_ADDR = 16'h0a1a;
	localparam addr_t DIVIDER2_HIGH_RATE_ADDR = 16'h0a20;
	localparam addr_t DIVIDER3_HIGH_RATE_ADDR = 16'h0a26;
	localparam addr_t DIVIDER4_HIGH_RATE_ADDR = 16'h0a2c;
	localparam addr_t RECONFIG_SCRATCH_A_ADDR = 16'h0b24;
	localparam addr_t RECONFIG_SCRATCH_B_ADDR = 16'h0b25;

	// Defined-bit masks per register; all other bits read zero
	localparam data_t RAMP_CONTROL_MASK = 8'h08;
	localparam data_t SINGLE_BIT_MASK = 8'h01;
	localparam data_t FULL_MASK = 8'hff;
	localparam data_t NIBBLE_MASK = 8'h0f;
	localparam data_t DIVIDER_MASK = 8'h1f;
	localparam data_t HIGH_RATE_MASK = 8'h08;

	// Field positions
	localparam int RAMP_ENABLE_BIT = 3;
	localparam int REF_PIN_EXT_BIT = 0;
	localparam int IO_LEVEL_BIT = 0;
	localparam int INPUT_ENABLE_LSB = 0;
	localparam int INPUT_FORMAT_LSB = 4;

	// Reset values: ramp switching defaults on, everything else off
	localparam data_t RAMP_CONTROL_RESET = 8'h08;
	localparam data_t ZERO_RESET = 8'h00;
endpackage
`default_nettype wire

//--- config_reg_cell.sv
// One masked configuration register with synchronous reset
`default_nettype none
module config_reg_cell #(
	parameter logic [7:0] MASK = 8'hff,
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic writeHit, // Write strobe aimed at this register
	input wire logic [7:0] writeData, // Data being written
	output logic [7:0] value // Stored value, undefined bits zero
);
	logic [7:0] valueReg;

	// Store defined bits only so reserved bits always read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			valueReg <= RESET_VALUE & MASK;
		end else if (writeHit) begin
			valueReg <= writeData & MASK;
		end
	end

	assign value = valueReg;
endmodule
`default_nettype wire

//--- clock_synth_config_regs.sv
// Configuration register bank of the clock synthesizer with its decoded control outputs
`default_nettype none
// Function
// RULE1: Ramp switching enable at 0x05A6 bit 3, one enables, enabled by default.
// RULE2: Reference pin select at 0x090E bit 0: zero crystal, one external clock.
// RULE3: Control I/O level at 0x0943 bit 0: zero 1.8 V, one 3.3 V.
// RULE4: Host with 3.3 V interface and 1.8 V core selects the higher level.
// RULE5: Input buffer enables at 0x0949 bits 3:0; zero powers that buffer down.
// RULE6: Input format bits 7:4 of 0x0949; one selects pulsed CMOS format.
// RULE7: Input n uses enable bit n and format bit n+4.
// RULE8: Route enables at 0x0A03 bits 4:0 pass divider clocks to output muxes.
// RULE9: Divide mode at 0x0A04 bits 4:0; zero fractional, one integer.
// RULE10: Host asserts soft reset after changing any divide mode bit.
// RULE11: Host keeps mode bit zero for dividers that will go fractional.
// RULE12: Divider whose power bit at 0x0A05 is zero is powered down.
// RULE13: 0x0B24 and 0x0B25 are full eight-bit read-write scratch registers.
// RULE14: Host clears divider clock disable at 0x0B4A to use a divider.
// RULE15: All registers eight bits; reads return written fields, reserved bits zero.
module clock_synth_config_regs
	import clock_synth_pkg::*;
#(
	parameter int INPUTS = clock_synth_pkg::NUM_INPUTS,
	parameter int DIVIDERS = clock_synth_pkg::NUM_DIVIDERS
) (
	input wire logic clk, // System clock, 10 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic regWrite, // Write strobe from serial interface logic
	input wire logic regRead, // Read strobe from serial interface logic
	input wire clock_synth_pkg::addr_t regAddr, // Full page plus offset address
	input wire clock_synth_pkg::data_t regWriteData, // Write data
	output clock_synth_pkg::data_t regReadData, // Registered read data
	output logic regReadValid, // One-cycle pulse with read data
	output logic regAddrHit, // High when address maps to a register
	output logic rampSwitchEnable, // Frequency-ramped switching on
	output logic refPinExternalSelect, // One external clock, zero crystal
	output logic ioLevelHigh, // One 3.3 V thresholds, zero 1.8 V
	output logic [INPUTS-1:0] inputBufferEnable, // Per-input buffer power
	output logic [INPUTS-1:0] inputPulsedFormat, // Per-input pulsed CMOS format
	output logic [DIVIDERS-1:0] dividerRouteEnable, // Divider to output muxes
	output logic [DIVIDERS-1:0] dividerIntegerMode, // One integer, zero fractional
	output logic [DIVIDERS-1:0] dividerPowerOn // Zero powers divider down
);
	import clock_synth_pkg::*;

	typedef logic [ADDR_W-1:0] addr_table_t [NUM_REGS];
	typedef logic [DATA_W-1:0] data_table_t [NUM_REGS];

	localparam addr_table_t REG_ADDRS = '{
		RAMP_CONTROL_ADDR, REF_PIN_CONFIG_ADDR, CONTROL_IO_LEVEL_ADDR, INPUT_BUFFER_CONTROL_ADDR,
		INPUT_TO_DETECTOR_ENABLE_ADDR, INPUT_HYSTERESIS_LOW_ADDR, INPUT_HYSTERESIS_HIGH_ADDR,
		FEEDBACK_DIVIDER_MODE_ADDR, DIVIDER_HALF_STEP_ADDR, DIVIDER_ROUTE_ENABLE_ADDR,
		DIVIDER_INTEGER_SELECT_ADDR, DIVIDER_POWER_ADDR, DIVIDER0_HIGH_RATE_ADDR,
		DIVIDER1_HIGH_RATE_ADDR, DIVIDER2_HIGH_RATE_ADDR, DIVIDER3_HIGH_RATE_ADDR,
		DIVIDER4_HIGH_RATE_ADDR, RECONFIG_SCRATCH_A_ADDR, RECONFIG_SCRATCH_B_ADDR
	};
	localparam data_table_t REG_MASKS = '{
		RAMP_CONTROL_MASK, SINGLE_BIT_MASK, SINGLE_BIT_MASK, FULL_MASK,
		NIBBLE_MASK, FULL_MASK, NIBBLE_MASK,
		SINGLE_BIT_MASK, DIVIDER_MASK, DIVIDER_MASK,
		DIVIDER_MASK, DIVIDER_MASK, HIGH_RATE_MASK,
		HIGH_RATE_MASK, HIGH_RATE_MASK, HIGH_RATE_MASK,
		HIGH_RATE_MASK, FULL_MASK, FULL_MASK // RULE13
	};
	localparam data_table_t REG_RESETS = '{
		RAMP_CONTROL_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET
	};

	// Index of the register at each table slot
	localparam int IDX_RAMP = 0;
	localparam int IDX_REF_PIN = 1;
	localparam int IDX_IO_LEVEL = 2;
	localparam int IDX_INPUT_CTRL = 3;
	localparam int IDX_ROUTE = 9;
	localparam int IDX_INTEGER = 10;
	localparam int IDX_POWER = 11;
	localparam int IDX_SCRATCH_A = 17;
	localparam int IDX_SCRATCH_B = 18;

	// Address decode shared by read and write paths
	function automatic logic [NUM_REGS-1:0] decodeAddr(input logic [ADDR_W-1:0] addr);
		logic [NUM_REGS-1:0] hits;
		hits = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			hits[i] = (addr == REG_ADDRS[i]);
		end
		return hits;
	endfunction

	logic [NUM_REGS-1:0] addrHits;
	data_t regValues [NUM_REGS];
	data_t readMux;
	data_t regReadData_reg;
	logic regReadValid_reg;

	assign addrHits = decodeAddr(regAddr);
	assign regAddrHit = |addrHits;

	// One masked storage cell per mapped register
	generate
		for (genvar g = 0; g < NUM_REGS; g++) begin : gen_regs
			config_reg_cell #(
				.MASK(REG_MASKS[g]),
				.RESET_VALUE(REG_RESETS[g])
			) u_cell (
				.clk(clk),
				.sys_rst(sys_rst),
				.writeHit(regWrite && addrHits[g]), // RULE15
				.writeData(regWriteData),
				.value(regValues[g])
			);
		end
	endgenerate

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		readMux = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (addrHits[i]) begin
				readMux = regValues[i]; // RULE15
			end
		end
	end

	// Registered read data and its valid pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regReadData_reg <= ZERO_RESET;
			regReadValid_reg <= 1'b0;
		end else begin
			regReadValid_reg <= regRead;
			if (regRead) begin
				regReadData_reg <= readMux;
			end
		end
	end

	assign regReadData = regReadData_reg;
	assign regReadValid = regReadValid_reg;

	// Single-bit controls
	assign rampSwitchEnable = regValues[IDX_RAMP][RAMP_ENABLE_BIT]; // RULE1
	assign refPinExternalSelect = regValues[IDX_REF_PIN][REF_PIN_EXT_BIT]; // RULE2
	assign ioLevelHigh = regValues[IDX_IO_LEVEL][IO_LEVEL_BIT]; // RULE3

	// Per-input enable and format bits
	generate
		for (genvar n = 0; n < INPUTS; n++) begin : gen_inputs
			assign inputBufferEnable[n] = regValues[IDX_INPUT_CTRL][INPUT_ENABLE_LSB + n]; // RULE5 RULE7
			assign inputPulsedFormat[n] = regValues[IDX_INPUT_CTRL][INPUT_FORMAT_LSB + n]; // RULE6 RULE7
		end
	endgenerate

	// Per-divider routing, mode and power
	assign dividerRouteEnable = regValues[IDX_ROUTE][DIVIDERS-1:0]; // RULE8
	assign dividerIntegerMode = regValues[IDX_INTEGER][DIVIDERS-1:0]; // RULE9
	assign dividerPowerOn = regValues[IDX_POWER][DIVIDERS-1:0]; // RULE12

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_ramp_reset_default: assert property ($past(sys_rst) |-> rampSwitchEnable) // RULE1
		else $error("ramp enable not set after reset");
	a_ramp_write: assert property (regWrite && regAddr == RAMP_CONTROL_ADDR // RULE1
		|=> rampSwitchEnable == $past(regWriteData[RAMP_ENABLE_BIT]))
		else $error("ramp enable not updated");
	a_ramp_hold: assert property (!(regWrite && regAddr == RAMP_CONTROL_ADDR) // RULE1
		|=> $stable(rampSwitchEnable))
		else $error("ramp enable changed without write");
	a_ref_pin_write: assert property (regWrite && regAddr == REF_PIN_CONFIG_ADDR // RULE2
		|=> refPinExternalSelect == $past(regWriteData[REF_PIN_EXT_BIT]))
		else $error("reference pin select not updated");
	a_ref_pin_hold: assert property (!(regWrite && regAddr == REF_PIN_CONFIG_ADDR) // RULE2
		|=> $stable(refPinExternalSelect))
		else $error("reference pin select changed without write");
	a_ref_pin_reset: assert property ($past(sys_rst) |-> !refPinExternalSelect) // RULE2
		else $error("reference pin select not cleared by reset");
	a_io_level_write: assert property (regWrite && regAddr == CONTROL_IO_LEVEL_ADDR // RULE3
		|=> ioLevelHigh == $past(regWriteData[IO_LEVEL_BIT]))
		else $error("io level select not updated");
	a_io_level_hold: assert property (!(regWrite && regAddr == CONTROL_IO_LEVEL_ADDR) // RULE3
		|=> $stable(ioLevelHigh))
		else $error("io level select changed without write");
	a_io_level_reset: assert property ($past(sys_rst) |-> !ioLevelHigh) // RULE3
		else $error("io level select not cleared by reset");

	// Input control register: enable nibble low, format nibble high
	a_input_ctrl_map: assert property (regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR // RULE5
		|=> inputBufferEnable == $past(regWriteData[3:0]) && inputPulsedFormat == $past(regWriteData[7:4]))
		else $error("input control fields mismatched");
	a_input_enable_hold: assert property (!(regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR) // RULE5
		|=> $stable(inputBufferEnable))
		else $error("input enable changed without write");
	a_input_reset: assert property ($past(sys_rst) // RULE5
		|-> inputBufferEnable == '0 && inputPulsedFormat == '0)
		else $error("input control not cleared by reset");
	a_input_zero_map: assert property (regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR && regWriteData == 8'h10 // RULE7
		|=> !inputBufferEnable[0] && inputPulsedFormat[0])
		else $error("input zero bit mapping wrong");
	a_input_enable_zero: assert property (regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR && regWriteData == 8'h01 // RULE7
		|=> inputBufferEnable[0] && !inputPulsedFormat[0])
		else $error("input zero enable mapping wrong");
	a_input_three_map: assert property (regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR && regWriteData == 8'h80 // RULE7
		|=> !inputBufferEnable[3] && inputPulsedFormat[3])
		else $error("input three bit mapping wrong");
	a_input_format_hold: assert property (!(regWrite && regAddr == INPUT_BUFFER_CONTROL_ADDR) // RULE6
		|=> $stable(inputPulsedFormat))
		else $error("input format changed without write");

	// Divider routing, mode and power fields
	a_route_write: assert property (regWrite && regAddr == DIVIDER_ROUTE_ENABLE_ADDR // RULE8
		|=> dividerRouteEnable == $past(regWriteData[4:0]))
		else $error("route enable not updated");
	a_route_hold: assert property (!(regWrite && regAddr == DIVIDER_ROUTE_ENABLE_ADDR) // RULE8
		|=> $stable(dividerRouteEnable))
		else $error("route enable changed without write");
	a_route_reset: assert property ($past(sys_rst) |-> dividerRouteEnable == '0) // RULE8
		else $error("route enable not cleared by reset");
	a_mode_write: assert property (regWrite && regAddr == DIVIDER_INTEGER_SELECT_ADDR // RULE9
		|=> dividerIntegerMode == $past(regWriteData[4:0]))
		else $error("divide mode not updated");
	a_mode_hold: assert property (!(regWrite && regAddr == DIVIDER_INTEGER_SELECT_ADDR) // RULE9
		|=> $stable(dividerIntegerMode))
		else $error("divide mode changed without write");
	a_mode_reset: assert property ($past(sys_rst) |-> dividerIntegerMode == '0) // RULE9
		else $error("divide mode not cleared by reset");
	a_power_write: assert property (regWrite && regAddr == DIVIDER_POWER_ADDR // RULE12
		|=> dividerPowerOn == $past(regWriteData[4:0]))
		else $error("divider power not updated");
	a_power_hold: assert property (!(regWrite && regAddr == DIVIDER_POWER_ADDR) // RULE12
		|=> $stable(dividerPowerOn))
		else $error("divider power changed without write");
	a_power_reset: assert property ($past(sys_rst) |-> dividerPowerOn == '0) // RULE12
		else $error("dividers not powered down by reset");

	// Scratch registers keep all eight bits
	a_scratch_readback: assert property (regWrite && regAddr == RECONFIG_SCRATCH_A_ADDR ##1 // RULE13
		regRead && regAddr == RECONFIG_SCRATCH_A_ADDR && !regWrite
		|=> regReadData == $past(regWriteData, 2))
		else $error("scratch register readback mismatch");
	a_scratch_b_readback: assert property (regWrite && regAddr == RECONFIG_SCRATCH_B_ADDR ##1 // RULE13
		regRead && regAddr == RECONFIG_SCRATCH_B_ADDR && !regWrite
		|=> regReadData == $past(regWriteData, 2))
		else $error("second scratch register readback mismatch");

	// Read path, decode and reserved bits
	a_reserved_zero: assert property (regReadValid && $past(regAddr) == CONTROL_IO_LEVEL_ADDR // RULE15
		|-> regReadData[7:1] == 7'h00)
		else $error("reserved bits read nonzero");
	a_reserved_ramp: assert property (regReadValid && $past(regAddr) == RAMP_CONTROL_ADDR // RULE15
		|-> (regReadData & ~RAMP_CONTROL_MASK) == ZERO_RESET)
		else $error("ramp register reserved bits nonzero");
	a_reserved_ref_pin: assert property (regReadValid && $past(regAddr) == REF_PIN_CONFIG_ADDR // RULE15
		|-> (regReadData & ~SINGLE_BIT_MASK) == ZERO_RESET)
		else $error("reference pin register reserved bits nonzero");
	a_reserved_detector: assert property (regReadValid && $past(regAddr) == INPUT_TO_DETECTOR_ENABLE_ADDR // RULE15
		|-> (regReadData & ~NIBBLE_MASK) == ZERO_RESET)
		else $error("detector enable reserved bits nonzero");
	a_reserved_hysteresis: assert property (regReadValid && $past(regAddr) == INPUT_HYSTERESIS_HIGH_ADDR // RULE15
		|-> (regReadData & ~NIBBLE_MASK) == ZERO_RESET)
		else $error("hysteresis reserved bits nonzero");
	a_reserved_feedback: assert property (regReadValid && $past(regAddr) == FEEDBACK_DIVIDER_MODE_ADDR // RULE15
		|-> (regReadData & ~SINGLE_BIT_MASK) == ZERO_RESET)
		else $error("feedback mode reserved bits nonzero");
	a_reserved_half_step: assert property (regReadValid && $past(regAddr) == DIVIDER_HALF_STEP_ADDR // RULE15
		|-> (regReadData & ~DIVIDER_MASK) == ZERO_RESET)
		else $error("half step reserved bits nonzero");
	a_reserved_route: assert property (regReadValid && $past(regAddr) == DIVIDER_ROUTE_ENABLE_ADDR // RULE15
		|-> (regReadData & ~DIVIDER_MASK) == ZERO_RESET)
		else $error("route reserved bits nonzero");
	a_reserved_mode: assert property (regReadValid && $past(regAddr) == DIVIDER_INTEGER_SELECT_ADDR // RULE15
		|-> (regReadData & ~DIVIDER_MASK) == ZERO_RESET)
		else $error("divide mode reserved bits nonzero");
	a_reserved_power: assert property (regReadValid && $past(regAddr) == DIVIDER_POWER_ADDR // RULE15
		|-> (regReadData & ~DIVIDER_MASK) == ZERO_RESET)
		else $error("power reserved bits nonzero");
	a_reserved_rate_zero: assert property (regReadValid && $past(regAddr) == DIVIDER0_HIGH_RATE_ADDR // RULE15
		|-> (regReadData & ~HIGH_RATE_MASK) == ZERO_RESET)
		else $error("divider zero rate reserved bits nonzero");
	a_reserved_rate_one: assert property (regReadValid && $past(regAddr) == DIVIDER1_HIGH_RATE_ADDR // RULE15
		|-> (regReadData & ~HIGH_RATE_MASK) == ZERO_RESET)
		else $error("divider one rate reserved bits nonzero");
	a_reserved_rate_two: assert property (regReadValid && $past(regAddr) == DIVIDER2_HIGH_RATE_ADDR // RULE15
		|-> (regReadData & ~HIGH_RATE_MASK) == ZERO_RESET)
		else $error("divider two rate reserved bits nonzero");
	a_reserved_rate_three: assert property (regReadValid && $past(regAddr) == DIVIDER3_HIGH_RATE_ADDR // RULE15
		|-> (regReadData & ~HIGH_RATE_MASK) == ZERO_RESET)
		else $error("divider three rate reserved bits nonzero");
	a_reserved_rate_four: assert property (regReadValid && $past(regAddr) == DIVIDER4_HIGH_RATE_ADDR // RULE15
		|-> (regReadData & ~HIGH_RATE_MASK) == ZERO_RESET)
		else $error("divider four rate reserved bits nonzero");
	a_unmapped_read_zero: assert property (regReadValid && !$past(regAddrHit) // RULE15
		|-> regReadData == ZERO_RESET)
		else $error("unmapped read returned nonzero");
	a_unmapped_write_ignored: assert property (regWrite && !regAddrHit // RULE15
		|=> $stable(rampSwitchEnable) && $stable(dividerPowerOn) && $stable(dividerIntegerMode))
		else $error("unmapped write changed a control");
	a_addr_hit_power: assert property (regAddr == DIVIDER_POWER_ADDR |-> regAddrHit) // RULE15
		else $error("power register address not decoded");
	a_addr_hit_scratch: assert property (regAddr == RECONFIG_SCRATCH_B_ADDR |-> regAddrHit) // RULE15
		else $error("scratch register address not decoded");
	a_read_valid_pulse: assert property (regRead |=> regReadValid) // RULE15
		else $error("read valid missing");
	a_valid_idle: assert property (!regRead |=> !regReadValid) // RULE15
		else $error("read valid without read");
	a_read_data_hold: assert property (!regReadValid && !$past(sys_rst) // RULE15
		|-> $stable(regReadData))
		else $error("read data changed without read");

	c_scratch_write: cover property (regWrite && regAddr == RECONFIG_SCRATCH_B_ADDR);
	c_input_three_pulsed: cover property (inputPulsedFormat[3] && !inputBufferEnable[3]);
	c_ramp_disable: cover property ($fell(rampSwitchEnable));
	c_all_dividers_on: cover property (dividerPowerOn == 5'h1f);
	c_unmapped_read: cover property (regRead && !regAddrHit);
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the synthesizer configuration register bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import clock_synth_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	addr_t regAddr = 16'h0000;
	data_t regWriteData = 8'h00;
	data_t regReadData;
	data_t rdVal;
	logic regReadValid, regAddrHit, rampSwitchEnable, refPinExternalSelect, ioLevelHigh;
	logic [3:0] inputBufferEnable, inputPulsedFormat;
	logic [4:0] dividerRouteEnable, dividerIntegerMode, dividerPowerOn;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 14146;
	data_t model [NUM_REGS];
	addr_t addrs [NUM_REGS] = '{RAMP_CONTROL_ADDR, REF_PIN_CONFIG_ADDR, CONTROL_IO_LEVEL_ADDR,
		INPUT_BUFFER_CONTROL_ADDR, INPUT_TO_DETECTOR_ENABLE_ADDR, INPUT_HYSTERESIS_LOW_ADDR,
		INPUT_HYSTERESIS_HIGH_ADDR, FEEDBACK_DIVIDER_MODE_ADDR, DIVIDER_HALF_STEP_ADDR,
		DIVIDER_ROUTE_ENABLE_ADDR, DIVIDER_INTEGER_SELECT_ADDR, DIVIDER_POWER_ADDR,
		DIVIDER0_HIGH_RATE_ADDR, DIVIDER1_HIGH_RATE_ADDR, DIVIDER2_HIGH_RATE_ADDR,
		DIVIDER3_HIGH_RATE_ADDR, DIVIDER4_HIGH_RATE_ADDR, RECONFIG_SCRATCH_A_ADDR, RECONFIG_SCRATCH_B_ADDR};
	data_t masks [NUM_REGS] = '{8'h08, 8'h01, 8'h01, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h01, 8'h1f, 8'h1f,
		8'h1f, 8'h1f, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'hff, 8'hff};

	// 10 MHz clock
	always #50 clk = ~clk;

	// Device under test
	clock_synth_config_regs u_clock_synth_config_regs (.clk(clk), .sys_rst(sys_rst), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
		.regReadValid(regReadValid), .regAddrHit(regAddrHit), .rampSwitchEnable(rampSwitchEnable),
		.refPinExternalSelect(refPinExternalSelect), .ioLevelHigh(ioLevelHigh),
		.inputBufferEnable(inputBufferEnable), .inputPulsedFormat(inputPulsedFormat),
		.dividerRouteEnable(dividerRouteEnable), .dividerIntegerMode(dividerIntegerMode),
		.dividerPowerOn(dividerPowerOn));

	// Expected value of a register right after reset
	function automatic data_t reset_of(input int i);
		return (i == 0) ? 8'h08 : 8'h00;
	endfunction

	task automatic chk(input data_t got, input data_t exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One write strobe, released a cycle later
	task automatic wr(input addr_t a, input data_t d);
		@(posedge clk);
		#1;
		regWrite = 1'b1;
		regAddr = a;
		regWriteData = d;
		@(posedge clk);
		#1;
		regWrite = 1'b0;
	endtask

	// One read strobe; data and valid are looked at in the answer cycle
	task automatic rd(input addr_t a, input logic hit, output data_t d);
		@(posedge clk);
		#1;
		regRead = 1'b1;
		regAddr = a;
		#1;
		chk({7'h00, regAddrHit}, {7'h00, hit});
		@(posedge clk);
		#1;
		regRead = 1'b0;
		chk({7'h00, regReadValid}, 8'h01);
		d = regReadData;
	endtask

	task automatic read_all();
		for (int i = 0; i < NUM_REGS; i++) begin
			rd(addrs[i], 1'b1, rdVal);
			chk(rdVal, model[i]);
		end
	endtask

	// Decoded control outputs against the shadow copy
	task automatic check_outputs();
		chk({7'h00, rampSwitchEnable}, {7'h00, model[0][3]});
		chk({7'h00, refPinExternalSelect}, {7'h00, model[1][0]});
		chk({7'h00, ioLevelHigh}, {7'h00, model[2][0]});
		chk({4'h0, inputBufferEnable}, {4'h0, model[3][3:0]});
		chk({4'h0, inputPulsedFormat}, {4'h0, model[3][7:4]});
		chk({3'h0, dividerRouteEnable}, {3'h0, model[9][4:0]});
		chk({3'h0, dividerIntegerMode}, {3'h0, model[10][4:0]});
		chk({3'h0, dividerPowerOn}, {3'h0, model[11][4:0]});
	endtask

	task automatic do_reset(input int n);
		@(posedge clk);
		#1;
		sys_rst = 1'b1;
		repeat (n) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < NUM_REGS; i++) model[i] = reset_of(i);
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		data_t d;
		do_reset(20);
		read_all();
		check_outputs();
		$display("test reset values done");
		for (int r = 0; r < 5; r++) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				d = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : data_t'($random(seed));
				wr(addrs[i], d);
				model[i] = d & masks[i];
				check_outputs();
			end
			read_all();
			$display("test write round %0d done", r);
		end
		for (int k = 0; k < 2; k++) begin
			wr((k == 0) ? 16'h0a06 : 16'h0b4a, (k == 0) ? 8'hff : 8'h00);
			rd((k == 0) ? 16'h0a06 : 16'h0b4a, 1'b0, rdVal);
			chk(rdVal, 8'h00);
		end
		read_all();
		$display("test unmapped access done");
		// Host bring-up: I/O level high, mode bits zero, power and routing on, clock disable cleared, integer mode, soft reset
		wr(CONTROL_IO_LEVEL_ADDR, 8'h01);
		wr(DIVIDER_INTEGER_SELECT_ADDR, 8'h00);
		wr(DIVIDER_POWER_ADDR, 8'h1f);
		wr(DIVIDER_ROUTE_ENABLE_ADDR, 8'h1f);
		wr(16'h0b4a, 8'h00);
		wr(DIVIDER_INTEGER_SELECT_ADDR, 8'h1f);
		wr(16'h001c, 8'h01);
		model[2] = 8'h01;
		model[9] = 8'h1f;
		model[10] = 8'h1f;
		model[11] = 8'h1f;
		check_outputs();
		// Single-input corners: enable bit n and format bit n+4
		wr(INPUT_BUFFER_CONTROL_ADDR, 8'h10);
		chk({inputBufferEnable, inputPulsedFormat}, 8'h01);
		wr(INPUT_BUFFER_CONTROL_ADDR, 8'h01);
		chk({inputBufferEnable, inputPulsedFormat}, 8'h10);
		wr(INPUT_BUFFER_CONTROL_ADDR, 8'h80);
		chk({inputBufferEnable, inputPulsedFormat}, 8'h08);
		model[3] = 8'h80;
		// Scratch write followed at once by its read
		for (int k = 0; k < 2; k++) begin
			d = data_t'($random(seed));
			@(posedge clk);
			#1;
			regWrite = 1'b1;
			regAddr = (k == 0) ? RECONFIG_SCRATCH_A_ADDR : RECONFIG_SCRATCH_B_ADDR;
			regWriteData = d;
			@(posedge clk);
			#1;
			regWrite = 1'b0;
			regRead = 1'b1;
			@(posedge clk);
			#1;
			regRead = 1'b0;
			chk(regReadData, d);
			model[17 + k] = d;
		end
		read_all();
		$display("test host sequence done");
		do_reset(2);
		read_all();
		check_outputs();
		$display("test second reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
